// [rtl/arpt_defines.svh]
// Register map, field positions, reset values and source codes of the stop/gate trigger block
`ifndef ARPT_DEFINES_SVH
`define ARPT_DEFINES_SVH

// Register byte offsets
`define ARPT_OFS_CTRL 8'h00
`define ARPT_OFS_STOP_SEL 8'h04
`define ARPT_OFS_GATE_SEL 8'h08
`define ARPT_OFS_PRE_CNT 8'h0c
`define ARPT_OFS_BUF_SIZE 8'h10
`define ARPT_OFS_ROUTE 8'h14
`define ARPT_OFS_STATUS 8'h18
`define ARPT_OFS_DATA 8'h1c

// Control bits (write one to act)
`define ARPT_CTRL_ARM 0
`define ARPT_CTRL_ABORT 1
// Selection fields
`define ARPT_SEL_W 6
`define ARPT_STOP_FALL_BIT 8
`define ARPT_GATE_LOW_BIT 8
// Route fields
`define ARPT_RT_STOP_LSB 0
`define ARPT_RT_STOP_EN 7
`define ARPT_RT_GATE_LSB 8
`define ARPT_RT_GATE_EN 15
// Status fields
`define ARPT_ST_DONE 4
`define ARPT_ST_PAUSED 5
`define ARPT_ST_LVL_LSB 8

// Reset values
`define ARPT_RST_SEL 6'h00
`define ARPT_RST_ROUTE 16'h0000

// Source codes
`define ARPT_NSRC 43
`define ARPT_SRC_ACMP 6'h2a
// Destination codes: 0-15 terminals, 16-23 sync, 24-31 pxi trig, 32 pxi star, 33 star out
`define ARPT_NDST 34
`define ARPT_DST_TRIG_LO 24
`define ARPT_DST_TRIG_HI 31
`define ARPT_DST_STAR 32

`endif

// [rtl/arpt_fifo.sv]
// Small valid/ready FIFO between the capture buffer and the bus
`timescale 1ns/1ps
module arpt_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH]; // Storage words
  logic [AW-1:0] wr_r; // Write index
  logic [AW-1:0] rd_r; // Read index
  logic [AW:0] cnt_r; // Occupancy
  logic push; // Accepted write
  logic pop; // Accepted read

  // Honest flags from occupancy
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rd_r];
  assign level = cnt_r;
  assign push = ce & in_valid & in_ready;
  assign pop = ce & out_ready & out_valid;

  // Data store, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  // Write index wraps at depth
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
    end else if (push) begin
      wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
    end
  end

  // Read index wraps at depth
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= '0;
    end else if (pop) begin
      rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
    end
  end

  // Occupancy follows push and pop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (push && !pop) begin
      cnt_r <= cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// [rtl/arpt_pkg.sv]
// Types shared by the stop/gate trigger block
package arpt_pkg;
  // Acquisition sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRE,
    ST_WAIT,
    ST_POST,
    ST_DRAIN
  } arpt_state_e;
endpackage

// [rtl/arpt_top.sv]
// Stop (reference) and gate (pause) trigger sequencer with circular capture buffer
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`include "arpt_defines.svh"
module arpt_top import arpt_pkg::*; #(
  parameter int SW = 16,
  parameter int DEPTH = 1024,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sample_tick_i,
  input wire logic [SW-1:0] sample_data_i,
  input wire logic [15:0] pft_i,
  output logic [15:0] pft_o,
  output logic [15:0] pft_oe_n,
  input wire logic [7:0] sync_line_i,
  output logic [7:0] sync_line_o,
  output logic [7:0] sync_line_oe_n,
  input wire logic pxi_star_i,
  output logic pxi_star_o,
  output logic pxi_star_oe_n,
  output logic [7:0] pxi_trig_o,
  output logic [7:0] pxi_trig_oe_n,
  output logic star_out_o,
  input wire logic [1:0] dstar_i,
  input wire logic acmp_event_i,
  input wire logic chg_det_i,
  input wire logic [3:0] ctr_out_i,
  input wire logic [3:0] ctr_gate_i,
  input wire logic digin_stop_trigger_i,
  input wire logic gen_begin_trigger_i,
  input wire logic digout_begin_trigger_i,
  input wire logic gen_gate_trigger_i,
  input wire logic digin_gate_trigger_i,
  input wire logic digout_gate_trigger_i,
  output logic sample_clk_gated_o,
  output logic acq_done_o,
  output logic acq_busy_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int NPIN = 28;

  // Reset release chain
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  logic rst_sn;
  assign rst_sn = rst_s2_r;

  // Pin inputs cross in through two flops; internal events are same-clock
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  assign pin_raw = {acmp_event_i, dstar_i, pxi_star_i, sync_line_i, pft_i};
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else if (ce) begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Full source vector, code equals bit index
  logic [`ARPT_NSRC-1:0] src_vec;
  assign src_vec = {pin_s2_r[27], digout_gate_trigger_i, digin_gate_trigger_i, gen_gate_trigger_i,
                    digout_begin_trigger_i, gen_begin_trigger_i, digin_stop_trigger_i,
                    ctr_gate_i, ctr_out_i, chg_det_i, pin_s2_r[26:0]};

  // Configuration registers
  logic [`ARPT_SEL_W-1:0] stop_sel_r; // Stop source code
  logic stop_fall_r; // Falling edge is the stop edge, except for the analog source
  logic [`ARPT_SEL_W-1:0] gate_sel_r; // Gate source code
  logic gate_low_r; // Gate active when low
  logic [CW-1:0] pre_cnt_r; // Pre-trigger samples
  logic [CW-1:0] buf_size_r; // Total buffer size
  logic [15:0] route_r; // Output routing

  // Bus decode
  logic wb_req;
  logic wb_wr;
  logic wb_rd;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce;
  assign wb_wr = wb_req & wb_we_i;
  assign wb_rd = wb_req & ~wb_we_i;

  // Software writes to configuration; low byte lane carries codes
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      stop_sel_r <= `ARPT_RST_SEL;
      stop_fall_r <= 1'b0;
      gate_sel_r <= `ARPT_RST_SEL;
      gate_low_r <= 1'b0;
      pre_cnt_r <= '0;
      buf_size_r <= '0;
      route_r <= `ARPT_RST_ROUTE;
    end else if (wb_wr) begin
      case (wb_adr_i)
        `ARPT_OFS_STOP_SEL: begin
          if (wb_sel_i[0]) stop_sel_r <= wb_dat_i[`ARPT_SEL_W-1:0];
          if (wb_sel_i[1]) stop_fall_r <= wb_dat_i[`ARPT_STOP_FALL_BIT];
        end
        `ARPT_OFS_GATE_SEL: begin
          if (wb_sel_i[0]) gate_sel_r <= wb_dat_i[`ARPT_SEL_W-1:0];
          if (wb_sel_i[1]) gate_low_r <= wb_dat_i[`ARPT_GATE_LOW_BIT];
        end
        `ARPT_OFS_PRE_CNT: begin
          pre_cnt_r <= wb_dat_i[CW-1:0];
        end
        `ARPT_OFS_BUF_SIZE: begin
          buf_size_r <= wb_dat_i[CW-1:0];
        end
        `ARPT_OFS_ROUTE: begin
          if (wb_sel_i[0]) route_r[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) route_r[15:8] <= wb_dat_i[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  // Command pulses from the control word
  logic arm_cmd;
  logic abort_cmd;
  assign arm_cmd = wb_wr && wb_adr_i == `ARPT_OFS_CTRL && wb_sel_i[0] && wb_dat_i[`ARPT_CTRL_ARM];
  assign abort_cmd = wb_wr && wb_adr_i == `ARPT_OFS_CTRL && wb_sel_i[0] && wb_dat_i[`ARPT_CTRL_ABORT];

  // Stop source edge detection; analog comparison always rising
  logic stop_lvl;
  logic stop_prev_r;
  logic stop_edge;
  // Codes past the last source read low, so a stale selection never feeds unknowns into the sequencer
  assign stop_lvl = (stop_sel_r < 6'(`ARPT_NSRC)) ? src_vec[stop_sel_r] : 1'b0;
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      stop_prev_r <= 1'b0;
    end else if (ce) begin
      stop_prev_r <= stop_lvl;
    end
  end
  always_comb begin
    if (stop_fall_r && stop_sel_r != `ARPT_SRC_ACMP) begin
      stop_edge = stop_prev_r & ~stop_lvl;
    end else begin
      stop_edge = ~stop_prev_r & stop_lvl;
    end
  end

  // Gate is a pure level with programmable sense, same for the analog source
  logic gate_act;
  logic gate_lvl; // Selected gate source, low for unused codes
  assign gate_lvl = (gate_sel_r < 6'(`ARPT_NSRC)) ? src_vec[gate_sel_r] : 1'b0;
  assign gate_act = gate_lvl ^ gate_low_r;

  // Sequencer state and counters
  arpt_state_e state_r;
  arpt_state_e state_nxt;
  logic [CW-1:0] cnt_r; // Samples in current phase
  logic [CW-1:0] cnt_nxt;
  logic [AW-1:0] wr_ptr_r; // Next capture slot
  logic [AW-1:0] wr_ptr_inc;
  logic [AW-1:0] rd_ptr_r; // Drain slot
  logic done_r; // Completion flag
  logic acquiring;
  logic store_en;
  logic [CW-1:0] post_cnt;
  logic push_ok; // FIFO accepts drained word

  // Post count is buffer size minus pre count
  assign post_cnt = buf_size_r - pre_cnt_r;
  assign acquiring = (state_r == ST_PRE) || (state_r == ST_WAIT) || (state_r == ST_POST);
  // Only ticks inside an unpaused acquisition store
  assign store_en = ce & sample_tick_i & acquiring & ~gate_act;
  // Circular wrap at the programmed size
  assign wr_ptr_inc = (CW'(wr_ptr_r) == buf_size_r - 1'b1) ? '0 : wr_ptr_r + 1'b1;

  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE: begin
        // Stop events here are ignored until software arms again
        if (arm_cmd) begin
          cnt_nxt = '0;
          state_nxt = (pre_cnt_r == '0) ? ST_WAIT : ST_PRE;
        end
      end
      ST_PRE: begin
        // Detector stays blind; early stop edges fall through
        if (store_en) begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r + 1'b1 == pre_cnt_r) begin
            state_nxt = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (stop_edge) begin
          cnt_nxt = store_en ? CW'(1) : '0;
          if (post_cnt == '0 || (store_en && post_cnt == CW'(1))) begin
            cnt_nxt = '0;
            state_nxt = ST_DRAIN;
          end else begin
            state_nxt = ST_POST;
          end
        end
      end
      ST_POST: begin
        // Further stop edges have no effect once accepted
        if (store_en) begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r + 1'b1 == post_cnt) begin
            cnt_nxt = '0;
            state_nxt = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        if (push_ok) begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r + 1'b1 == buf_size_r) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (abort_cmd) begin
      state_nxt = ST_IDLE;
      cnt_nxt = '0;
    end
  end

  // State and phase counter
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Capture pointer; restarts at slot zero on arm
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      wr_ptr_r <= '0;
    end else if (ce) begin
      if (state_r == ST_IDLE && arm_cmd) begin
        wr_ptr_r <= '0;
      end else if (store_en) begin
        wr_ptr_r <= wr_ptr_inc;
      end
    end
  end

  // Drain pointer starts at the oldest slot, which is the next write slot
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      rd_ptr_r <= '0;
    end else if (ce) begin
      if (state_r != ST_DRAIN && state_nxt == ST_DRAIN) begin
        rd_ptr_r <= store_en ? wr_ptr_inc : wr_ptr_r;
      end else if (push_ok) begin
        rd_ptr_r <= (CW'(rd_ptr_r) == buf_size_r - 1'b1) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  // Capture memory; each store overwrites the oldest slot once full
  logic [SW-1:0] cap_mem [DEPTH];
  always_ff @(posedge clk) begin
    if (store_en) begin
      cap_mem[wr_ptr_r] <= sample_data_i;
    end
  end

  // Completion flag, cleared by the next arm
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      done_r <= 1'b0;
    end else if (ce) begin
      if (state_r == ST_DRAIN && state_nxt == ST_IDLE && !abort_cmd) begin
        done_r <= 1'b1;
      end else if (arm_cmd && state_r == ST_IDLE) begin
        done_r <= 1'b0;
      end
    end
  end

  // Output FIFO toward the bus; stalls the drain when full
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [SW-1:0] fifo_out_data;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic fifo_pop;
  assign push_ok = ce & (state_r == ST_DRAIN) & fifo_in_ready;
  assign fifo_pop = wb_rd && wb_adr_i == `ARPT_OFS_DATA;

  arpt_fifo #(
    .W(SW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_sn),
    .ce(ce),
    .in_valid(state_r == ST_DRAIN),
    .in_ready(fifo_in_ready),
    .in_data(cap_mem[rd_ptr_r]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Read mux; unmapped addresses read zero
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `ARPT_OFS_STOP_SEL: begin
        rd_data[`ARPT_SEL_W-1:0] = stop_sel_r;
        rd_data[`ARPT_STOP_FALL_BIT] = stop_fall_r;
      end
      `ARPT_OFS_GATE_SEL: begin
        rd_data[`ARPT_SEL_W-1:0] = gate_sel_r;
        rd_data[`ARPT_GATE_LOW_BIT] = gate_low_r;
      end
      `ARPT_OFS_PRE_CNT: rd_data[CW-1:0] = pre_cnt_r;
      `ARPT_OFS_BUF_SIZE: rd_data[CW-1:0] = buf_size_r;
      `ARPT_OFS_ROUTE: rd_data[15:0] = route_r;
      `ARPT_OFS_STATUS: begin
        rd_data[2:0] = state_r;
        rd_data[`ARPT_ST_DONE] = done_r;
        rd_data[`ARPT_ST_PAUSED] = gate_act;
        rd_data[`ARPT_ST_LVL_LSB +: $clog2(FIFO_DEPTH)+1] = fifo_level;
      end
      `ARPT_OFS_DATA: begin
        // Bit 31 tells software whether the word is real
        rd_data[SW-1:0] = fifo_out_valid ? fifo_out_data : '0;
        rd_data[31] = fifo_out_valid;
      end
      default: begin
      end
    endcase
  end

  // Single-cycle acknowledge, dropped the cycle after
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= wb_req;
      if (wb_rd) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // One-cycle stop pulse for routing out
  logic stop_pulse_r;
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      stop_pulse_r <= 1'b0;
    end else if (ce) begin
      stop_pulse_r <= (state_r == ST_WAIT) & stop_edge;
    end
  end

  // Route fields
  logic [5:0] stop_dst;
  logic [5:0] gate_dst;
  assign stop_dst = route_r[`ARPT_RT_STOP_LSB +: 6];
  assign gate_dst = route_r[`ARPT_RT_GATE_LSB +: 6];

  // Per-destination drivers; terminals stay inputs until routed
  logic [`ARPT_NDST-1:0] dst_o_r;
  logic [`ARPT_NDST-1:0] dst_oe_n_r;
  genvar gi;
  generate
    for (gi = 0; gi < `ARPT_NDST; gi++) begin : g_dst
      logic stop_here;
      logic gate_here;
      // Stop cannot go to pxi star; gate cannot go to pxi trig lines
      assign stop_here = route_r[`ARPT_RT_STOP_EN] && stop_dst == 6'(gi) && gi != `ARPT_DST_STAR;
      assign gate_here = route_r[`ARPT_RT_GATE_EN] && gate_dst == 6'(gi)
                         && !(gi >= `ARPT_DST_TRIG_LO && gi <= `ARPT_DST_TRIG_HI);
      always_ff @(posedge clk or negedge rst_sn) begin
        if (!rst_sn) begin
          dst_o_r[gi] <= 1'b0;
          dst_oe_n_r[gi] <= 1'b1;
        end else if (ce) begin
          dst_o_r[gi] <= (stop_here & stop_pulse_r) | (gate_here & gate_act);
          dst_oe_n_r[gi] <= ~(stop_here | gate_here);
        end
      end
    end
  endgenerate
  assign pft_o = dst_o_r[15:0];
  assign pft_oe_n = dst_oe_n_r[15:0];
  assign sync_line_o = dst_o_r[23:16];
  assign sync_line_oe_n = dst_oe_n_r[23:16];
  assign pxi_trig_o = dst_o_r[31:24];
  assign pxi_trig_oe_n = dst_oe_n_r[31:24];
  assign pxi_star_o = dst_o_r[32];
  assign pxi_star_oe_n = dst_oe_n_r[32];
  assign star_out_o = dst_o_r[33];

  // Status outputs and gated sample clock
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      sample_clk_gated_o <= 1'b0;
      acq_done_o <= 1'b0;
      acq_busy_o <= 1'b0;
    end else if (ce) begin
      sample_clk_gated_o <= store_en;
      acq_done_o <= done_r;
      acq_busy_o <= (state_r != ST_IDLE);
    end
  end
endmodule

// [verification/acq_reference_pause_trigger_test.sv]
// Self-checking bench of the stop and gate trigger sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module acq_reference_pause_trigger_test;
  logic clk = 1'b0; // 125 MHz
  logic rst_n = 1'b0; // Held low at start
  logic req = 1'b0; // Drives cyc and stb together
  logic we = 1'b0; // Bus direction
  logic [7:0] adr = 8'h00; // Byte address
  logic [31:0] wdat = 32'h0; // Write data
  logic [42:0] src = '0; // Trigger source levels, by source code
  logic ld = 1'b0, clr = 1'b0; // Model controls
  logic [7:0] ld_n = 8'h00; // Ticks asked of the model
  logic tick, idle; // Model outputs
  logic [15:0] sdat; // Sample word
  logic [31:0] wb_dat_o;
  logic wb_ack_o, pxi_star_o, pxi_star_oe_n, star_out_o, sample_clk_gated_o, acq_done_o, acq_busy_o;
  logic [15:0] pft_o, pft_oe_n;
  logic [7:0] sync_line_o, sync_line_oe_n, pxi_trig_o, pxi_trig_oe_n;
  int failures = 0, tests_run = 0, cyc_n = 0, stored = 0, trig = 0;
  arpt_top #(.DEPTH(16)) u_dut (.clk, .rst_n, .ce(1'b1), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .sample_tick_i(tick),
    .sample_data_i(sdat), .pft_i(src[15:0]), .pft_o, .pft_oe_n, .sync_line_i(src[23:16]), .sync_line_o,
    .sync_line_oe_n, .pxi_star_i(src[24]), .pxi_star_o, .pxi_star_oe_n, .pxi_trig_o, .pxi_trig_oe_n,
    .star_out_o, .dstar_i(src[26:25]), .acmp_event_i(src[42]), .chg_det_i(src[27]), .ctr_out_i(src[31:28]),
    .ctr_gate_i(src[35:32]), .digin_stop_trigger_i(src[36]), .gen_begin_trigger_i(src[37]),
    .digout_begin_trigger_i(src[38]), .gen_gate_trigger_i(src[39]), .digin_gate_trigger_i(src[40]),
    .digout_gate_trigger_i(src[41]), .sample_clk_gated_o, .acq_done_o, .acq_busy_o);
  arpt_src_model u_src (.clk, .clr, .n_req(ld_n), .load(ld), .tick, .data(sdat), .idle);
  // Free-running clock
  initial begin
    forever #4 clk = ~clk;
  end
  // Stored-sample and stop-pulse counters; hang guard
  always @(posedge clk) begin
    stored <= stored + int'(sample_clk_gated_o === 1'b1);
    trig <= trig + int'(pxi_trig_o[0] === 1'b1);
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Classic single cycle; waits up to 40 cycles for ack, then counts a failure
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o;
    req <= 1'b0;
    we <= 1'b0;
    if (n == 40) begin
      failures++;
      $display("[FAIL] %0t no acknowledge", $time);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask
  // Change one source, then let the pin synchronisers settle
  task automatic setsrc(input int c, input logic v);
    @(posedge clk);
    src[c] <= v;
    repeat (4) @(posedge clk);
  endtask
  task automatic ticks(input logic [7:0] n);
    int k;
    @(posedge clk);
    ld_n <= n;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    for (k = 0; k < 300 && idle !== 1'b1; k++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  // Fresh data count, stop select, counts, then arm
  task automatic cfg(input logic [31:0] sel, input logic [31:0] size, input logic [31:0] pre);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wr(8'h04, sel);
    wr(8'h0c, pre);
    wr(8'h10, size);
    wr(8'h00, 32'h1);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    rd(8'h18, q);
    `CHK(q, 32'h0)
    rd(8'h04, q);
    `CHK(q, 32'h0)
    wr(8'h04, 32'h13f);
    rd(8'h04, q);
    `CHK(q, 32'h13f)
    wr(8'h40, 32'hffff);
    rd(8'h40, q);
    `CHK(q, 32'h0)
    `CHK(pft_oe_n, 16'hffff)
    `CHK({pft_o, sync_line_o, star_out_o}, 25'h0)
    $display("regs done");
  endtask
  // Every source code, both polarities, as gate source
  task automatic t_mux();
    logic [31:0] q;
    cfg(32'h3f, 32'd16, 32'd16);
    for (int c = 0; c < 43; c++) begin
      for (int p = 0; p < 2; p++) begin
        wr(8'h08, {23'h0, p[0], 2'b00, c[5:0]});
        setsrc(c, ~p[0]);
        rd(8'h18, q);
        `CHK(q[5], 1'b1)
        setsrc(c, p[0]);
        rd(8'h18, q);
        `CHK(q[5], 1'b0)
      end
    end
    wr(8'h00, 32'h2);
    src <= '0;
    $display("mux done");
  endtask
  task automatic t_gate();
    logic [31:0] q;
    int s0;
    wr(8'h14, 32'ha098);
    cfg(32'h0, 32'd16, 32'd16);
    wr(8'h08, 32'h1);
    setsrc(1, 1'b1);
    `CHK(pxi_star_oe_n, 1'b0)
    `CHK(pxi_star_o, 1'b1)
    `CHK(pxi_trig_oe_n[0], 1'b0)
    s0 = stored;
    ticks(3);
    `CHK(stored - s0, 0)
    setsrc(1, 1'b0);
    ticks(2);
    `CHK(stored - s0, 2)
    wr(8'h00, 32'h2);
    wr(8'h08, 32'h3f);
    rd(8'h18, q);
    `CHK(q[4:0], 5'h0)
    $display("gate done");
  endtask
  // Ten-word buffer, three pre samples, early and late stop edges
  task automatic t_capture(input int c, input logic f);
    logic [31:0] q;
    int s0, t0;
    setsrc(c, f);
    cfg({23'h0, f, 2'b00, c[5:0]}, 32'd10, 32'd3);
    s0 = stored;
    t0 = trig;
    ticks(1);
    setsrc(c, ~f);
    setsrc(c, f);
    rd(8'h18, q);
    `CHK(q[2:0], 3'h1)
    ticks(11);
    rd(8'h18, q);
    `CHK(q[2:0], 3'h2)
    setsrc(c, ~f);
    rd(8'h18, q);
    `CHK(q[2:0], 3'h3)
    setsrc(c, f);
    setsrc(c, ~f);
    ticks(7);
    repeat (20) @(posedge clk);
    rd(8'h18, q);
    `CHK(q[11:8], 4'h8)
    for (int k = 10; k < 20; k++) begin
      rd(8'h1c, q);
      `CHK(q, {1'b1, 15'h0, 16'(k)})
    end
    rd(8'h1c, q);
    `CHK(q[31], 1'b0)
    rd(8'h18, q);
    `CHK(q[4:0], 5'h10)
    `CHK(acq_done_o, 1'b1)
    `CHK(trig - t0, 1)
    `CHK(stored - s0, 19)
    $display("capture done");
  endtask
  // Analog source stops on rising edge only, even with falling chosen
  task automatic t_analog();
    logic [31:0] q;
    setsrc(42, 1'b1);
    cfg(32'h12a, 32'd2, 32'd0);
    rd(8'h18, q);
    `CHK(q[2:0], 3'h2)
    setsrc(42, 1'b0);
    rd(8'h18, q);
    `CHK(q[2:0], 3'h2)
    setsrc(42, 1'b1);
    rd(8'h18, q);
    `CHK(q[2:0], 3'h3)
    ticks(2);
    repeat (20) @(posedge clk);
    rd(8'h1c, q);
    `CHK(q, 32'h80000001)
    rd(8'h1c, q);
    `CHK(q, 32'h80000002)
    $display("analog done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    `CHK(pft_oe_n, 16'hffff)
    `CHK(sync_line_oe_n, 8'hff)
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_mux();
    t_gate();
    t_capture(0, 1'b0);
    t_capture(16, 1'b1);
    t_analog();
    give_verdict();
  end
endmodule

// [verification/arpt_src_model.sv]
// Sample clock and sample data source feeding the capture block
`timescale 1ns/1ps
module arpt_src_model #(
  parameter int SW = 16
) (
  input wire logic clk,
  input wire logic clr,
  input wire logic [7:0] n_req,
  input wire logic load,
  output logic tick,
  output logic [SW-1:0] data,
  output logic idle
);
  logic [7:0] left_r = 8'h00; // Ticks still owed
  logic [1:0] gap_r = 2'h0; // Spacing of ticks
  logic [SW-1:0] cnt_r = '0; // Last value sent
  logic tick_r = 1'b0; // Tick pulse
  // One tick each fourth cycle; data shows the inverse between ticks so stale values never match
  always_ff @(posedge clk) begin
    gap_r <= gap_r + 2'h1;
    tick_r <= 1'b0;
    data <= ~cnt_r;
    if (clr) begin
      cnt_r <= '0;
    end
    if (load) begin
      left_r <= n_req;
    end else if (left_r != 8'h00 && gap_r == 2'h3) begin
      tick_r <= 1'b1;
      data <= cnt_r + 1'b1;
      cnt_r <= cnt_r + 1'b1;
      left_r <= left_r - 8'h01;
    end
  end
  assign tick = tick_r;
  assign idle = (left_r == 8'h00) && !load;
endmodule

// [verification/arpt_top_props.sv]
// Port-level checks of the trigger sequencer
`timescale 1ns/1ps
module arpt_top_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic sample_tick_i,
  input wire logic sample_clk_gated_o,
  input wire logic [15:0] pft_oe_n,
  input wire logic [7:0] sync_line_oe_n,
  input wire logic pxi_star_oe_n,
  input wire logic [7:0] pxi_trig_o,
  input wire logic [7:0] pxi_trig_oe_n,
  input wire logic acq_done_o,
  input wire logic acq_busy_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire cs_w = wb_cyc_i & wb_stb_i; // Bus request present
  wire wr_w = cs_w & wb_we_i; // Bus write present
  wire [32:0] oe_w = {pft_oe_n, sync_line_oe_n, pxi_trig_oe_n, pxi_star_oe_n}; // All pin enables
  // Request not yet answered
  sequence s_req;
    cs_w && !wb_ack_o && ce;
  endsequence
  // Write one or two edges back; the enable lags the write
  sequence s_wr_back;
    $past(wr_w) || $past(wr_w, 2);
  endsequence
  a_ack_after_req: assert property (s_req |=> wb_ack_o) else $error("request not acked");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_only_asked: assert property (wb_ack_o |-> $past(cs_w)) else $error("ack without request");
  a_store_on_tick: assert property (
    sample_clk_gated_o |-> $past(sample_tick_i)) else $error("sample stored without tick");
  a_idle_no_store: assert property (
    acq_done_o && !acq_busy_o |-> !sample_clk_gated_o) else $error("sample stored while idle");
  a_done_when_idle: assert property ($rose(acq_done_o) |-> !acq_busy_o) else $error("done while busy");
  a_oe_after_write: assert property (
    $changed(oe_w) |-> s_wr_back) else $error("pin direction changed without write");
  a_trig_one_pulse: assert property ((|pxi_trig_o) |=> !(|pxi_trig_o)) else $error("stop pulse too long");
endmodule
bind arpt_top arpt_top_props u_props (.clk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .sample_tick_i, .sample_clk_gated_o, .pft_oe_n, .sync_line_oe_n, .pxi_star_oe_n, .pxi_trig_o,
  .pxi_trig_oe_n, .acq_done_o, .acq_busy_o);
